// file: gpif_pkg.sv
package gpif_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_NUM = 8'h04;
  localparam logic [7:0] ADDR_DEN = 8'h08;
  localparam logic [7:0] ADDR_XRES = 8'h0c;
  localparam logic [7:0] ADDR_MRES = 8'h10;
  localparam logic [7:0] ADDR_IFS = 8'h14;
  localparam logic [7:0] ADDR_EXTCNT = 8'h18;
  localparam logic [7:0] ADDR_CMD = 8'h1c;
  localparam logic [7:0] ADDR_ERR = 8'h20;
  localparam logic [7:0] ADDR_ACTUAL = 8'h24;
  // Control word fields
  localparam int CTRL_ENGAGE_BIT = 0;
  localparam int CTRL_MULT_BIT = 1;
  localparam int CTRL_SRC_LSB = 4;
  localparam int SRC_W = 3;
  // Input function fields
  localparam int IFS_IN5_LSB = 0;
  localparam int IFS_IN6_LSB = 8;
  localparam int IFS_W = 5;
  localparam logic [4:0] FUNC_PULSE = 5'h11;
  localparam logic [4:0] FUNC_DIR = 5'h12;
  // Gear source selection codes
  localparam logic [2:0] SRC_QUAD_CTRL = 3'h0;
  localparam logic [2:0] SRC_PDIR_CTRL = 3'h1;
  localparam logic [2:0] SRC_UPDN_CTRL = 3'h2;
  localparam logic [2:0] SRC_QUAD_MACH = 3'h3;
  localparam logic [2:0] SRC_PDIR_MACH = 3'h4;
  // Reset values
  localparam logic [15:0] NUM_RST = 16'h0001;
  localparam logic [15:0] DEN_RST = 16'h0001;
  localparam logic [15:0] XRES_RST = 16'h0004;
  localparam logic [15:0] MRES_RST = 16'h0001;
  // Counts per line after quadrature, as a shift
  localparam int QUAD_SHIFT = 2;
  // Decoding method, one-hot
  typedef enum logic [3:0] {
    KIND_NONE = 4'b0001,
    KIND_QUAD = 4'b0010,
    KIND_PDIR = 4'b0100,
    KIND_UPDN = 4'b1000
  } gpif_kind_e;
endpackage

// file: gpif_dec_if.sv
`timescale 1ns/1ps
interface gpif_dec_if;
  import gpif_pkg::*;
  logic raw_a; // Selected pin, not yet synchronised
  logic raw_b;
  gpif_kind_e kind; // Decoding method
  logic filter_en; // Pulse-reading multiplier on
  logic step_up; // One count up
  logic step_down; // One count down
  modport dec (input raw_a, input raw_b, input kind, input filter_en, output step_up, output step_down);
  modport ctl (output raw_a, output raw_b, output kind, output filter_en, input step_up, input step_down);
endinterface

// file: gpif_decoder.sv
`timescale 1ns/1ps
module gpif_decoder
  import gpif_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  gpif_dec_if.dec d
);
  // All decoder state
  typedef struct packed {
    logic a_s1; logic a_s2; logic b_s1; logic b_s2; // Synchronisers
    logic a_h; logic b_h; // One sample of history for the filter
    logic a_f; logic b_f; // Filtered levels
    logic a_p; logic b_p; // Filtered levels one clock ago
    logic up; logic dn; // Registered step outputs
  } gpif_dec_s;
  gpif_dec_s s_q, s_d;
  logic a_rise, a_fall, b_rise, b_fall, one_chg;

  // Edge terms on the filtered levels
  assign a_rise = s_q.a_f & ~s_q.a_p;
  assign a_fall = ~s_q.a_f & s_q.a_p;
  assign b_rise = s_q.b_f & ~s_q.b_p;
  assign b_fall = ~s_q.b_f & s_q.b_p;
  assign one_chg = (a_rise | a_fall) ^ (b_rise | b_fall);

  // Next state: sync, filter, decode
  always_comb
  begin
    s_d = s_q;
    s_d.a_s1 = d.raw_a;
    s_d.a_s2 = s_q.a_s1;
    s_d.b_s1 = d.raw_b;
    s_d.b_s2 = s_q.b_s1;
    s_d.a_h = s_q.a_s2;
    s_d.b_h = s_q.b_s2;
    // Filter takes a level only after two equal samples; costs one clock
    if (!d.filter_en || s_q.a_s2 == s_q.a_h) s_d.a_f = s_q.a_s2;
    if (!d.filter_en || s_q.b_s2 == s_q.b_h) s_d.b_f = s_q.b_s2;
    s_d.a_p = s_q.a_f;
    s_d.b_p = s_q.b_f;
    s_d.up = 1'b0;
    s_d.dn = 1'b0;
    unique case (d.kind)
      KIND_PDIR:
      begin
        // Direction level sampled at the pulse edge; high counts up
        s_d.up = a_rise & s_q.b_f;
        s_d.dn = a_rise & ~s_q.b_f;
      end
      KIND_QUAD:
      begin
        // A leading B counts up; a double change is ignored as illegal
        s_d.up = one_chg & ((a_rise & ~s_q.b_f) | (b_rise & s_q.a_f) |
          (a_fall & s_q.b_f) | (b_fall & ~s_q.a_f));
        s_d.dn = one_chg & ((a_rise & s_q.b_f) | (b_rise & ~s_q.a_f) |
          (a_fall & ~s_q.b_f) | (b_fall & s_q.a_f));
      end
      KIND_UPDN:
      begin
        // Simultaneous up and down cancel
        s_d.up = a_rise & ~b_rise;
        s_d.dn = b_rise & ~a_rise;
      end
      KIND_NONE:
      begin
        s_d.up = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) s_q <= '0;
    else s_q <= s_d;
  end

  assign d.step_up = s_q.up;
  assign d.step_down = s_q.dn;

  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  pdir_dir_a: assert property (d.kind == KIND_PDIR && $rose(s_q.a_f) && !s_q.b_f |=> d.step_down && !d.step_up)
    else $error("Pulse with low direction did not count down");
  quad_lead_a: assert property (d.kind == KIND_QUAD && $rose(s_q.a_f) && !s_q.b_f && $stable(s_q.b_f) |=> d.step_up)
    else $error("A leading B did not count up");
endmodule

// file: gpif_top.sv
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - Pulse rising edge counts one, per direction
// - Geared counter value becomes position command
// - Error is command minus actual position
// - Unity ratio, resolution 4x: pulse equals count
// - Select 1 controller port, 4 machine port
// - Fast inputs 5/6 with codes 17/18
// - Resolution, multiplier, divider set displacement per pulse
// - Quadrature phase order sets direction
// - Follower resolution in lines, four counts each
// - Select 0 controller quadrature, 3 machine
// - Up/down: A pulse counts up
// - Up/down: B pulse counts down
// - Select 2 up/down from controller port
// - Command follows pulse rate, no limit; here the command moves at most one count per clock
// - Numerator sign sets rotation direction
module gpif_top
  import gpif_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ctrl_a_in,
  input wire logic ctrl_b_in,
  input wire logic mach_a_in,
  input wire logic mach_b_in,
  input wire logic fast_in5,
  input wire logic fast_in6,
  input wire logic signed [31:0] actual_motor_position,
  output logic signed [31:0] position_command,
  output logic signed [31:0] position_error,
  output logic move_fwd,
  output logic move_rev
);
  // All block state
  typedef struct packed {
    logic engaged; // Gearing active
    logic mult_en; // Pulse-reading multiplier
    logic [2:0] src; // Gear source selection
    logic signed [15:0] num; // Ratio numerator, signed
    logic [15:0] den; // Ratio denominator
    logic [15:0] xres; // External source resolution
    logic [15:0] mres; // Motor encoder lines
    logic [4:0] in5_func; // Fast input 5 function
    logic [4:0] in6_func; // Fast input 6 function
    logic signed [31:0] ext_cnt; // External pulse position counter
    logic signed [31:0] cmd; // Geared command
    logic signed [39:0] acc; // Remainder numerator
    logic signed [31:0] err; // Position error
    logic [31:0] rdata; // Read data, caught in setup
  } gpif_top_s;
  gpif_top_s s_q, s_d;

  gpif_dec_if dif ();
  logic fast_sel; // Fast inputs override controller pins
  logic quad_mode; // Follower counting, four per line
  logic signed [39:0] step; // Added per input count
  logic signed [39:0] dd; // Remainder wrap value
  logic wr_en; // Write in access phase
  logic rd_setup; // Read setup phase

  // Map decode for the error answer; read data has its own case
  function automatic logic gpif_mapped(input logic [7:0] a);
    return a == ADDR_CTRL || a == ADDR_NUM || a == ADDR_DEN || a == ADDR_XRES ||
      a == ADDR_MRES || a == ADDR_IFS || a == ADDR_EXTCNT || a == ADDR_CMD ||
      a == ADDR_ERR || a == ADDR_ACTUAL;
  endfunction

  // Read multiplexer; unused bits read as zero, numerator upper half reads as its sign
  function automatic logic [31:0] gpif_read(input gpif_top_s s, input logic [7:0] a,
    input logic signed [31:0] act);
    logic [31:0] r;
    r = 32'h0;
    unique case (a)
      ADDR_CTRL:
      begin
        r[CTRL_ENGAGE_BIT] = s.engaged;
        r[CTRL_MULT_BIT] = s.mult_en;
        r[CTRL_SRC_LSB +: SRC_W] = s.src;
      end
      ADDR_NUM: r = 32'(s.num);
      ADDR_DEN: r[15:0] = s.den;
      ADDR_XRES: r[15:0] = s.xres;
      ADDR_MRES: r[15:0] = s.mres;
      ADDR_IFS:
      begin
        r[IFS_IN5_LSB +: IFS_W] = s.in5_func;
        r[IFS_IN6_LSB +: IFS_W] = s.in6_func;
      end
      ADDR_EXTCNT: r = s.ext_cnt;
      ADDR_CMD: r = s.cmd;
      ADDR_ERR: r = s.err;
      ADDR_ACTUAL: r = act;
      default: r = 32'h0;
    endcase
    return r;
  endfunction

  // Source selection, ahead of the synchronisers in the decoder.
  // Changing the selection may look like an edge; change it while idle.
  always_comb
  begin
    fast_sel = s_q.in5_func == FUNC_PULSE && s_q.in6_func == FUNC_DIR;
    dif.filter_en = s_q.mult_en;
    dif.raw_a = fast_sel ? fast_in5 : ctrl_a_in;
    dif.raw_b = fast_sel ? fast_in6 : ctrl_b_in;
    dif.kind = KIND_NONE;
    quad_mode = 1'b0;
    unique case (s_q.src)
      SRC_QUAD_CTRL:
      begin
        dif.kind = KIND_QUAD;
        quad_mode = 1'b1;
      end
      SRC_PDIR_CTRL: dif.kind = KIND_PDIR;
      SRC_UPDN_CTRL: dif.kind = KIND_UPDN;
      SRC_QUAD_MACH:
      begin
        dif.kind = KIND_QUAD;
        quad_mode = 1'b1;
        dif.raw_a = mach_a_in;
        dif.raw_b = mach_b_in;
      end
      SRC_PDIR_MACH:
      begin
        dif.kind = KIND_PDIR;
        dif.raw_a = mach_a_in;
        dif.raw_b = mach_b_in;
      end
      default: dif.kind = KIND_NONE;
    endcase
  end

  gpif_decoder u_dec (
    .pclk(pclk),
    .presetn(presetn),
    .d(dif.dec)
  );

  // Gear fraction: motor counts per rev over source counts per rev.
  // Step carries the numerator sign, so the command turns with it.
  always_comb
  begin
    step = 40'(s_q.num) * $signed({22'h0, s_q.mres, 2'b00});
    dd = $signed(40'(s_q.den) * 40'(s_q.xres));
    if (quad_mode) dd = dd <<< QUAD_SHIFT;
  end

  // APB strobes; zero wait states
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !gpif_mapped(paddr);

  // Next state
  always_comb
  begin
    s_d = s_q;
    // Register writes; read-only offsets ignore writes
    if (wr_en)
    begin
      unique case (paddr)
        ADDR_CTRL:
        begin
          s_d.engaged = pwdata[CTRL_ENGAGE_BIT];
          s_d.mult_en = pwdata[CTRL_MULT_BIT];
          s_d.src = pwdata[CTRL_SRC_LSB +: SRC_W];
        end
        ADDR_NUM: s_d.num = $signed(pwdata[15:0]);
        ADDR_DEN: s_d.den = pwdata[15:0];
        ADDR_XRES: s_d.xres = pwdata[15:0];
        ADDR_MRES: s_d.mres = pwdata[15:0];
        ADDR_IFS:
        begin
          s_d.in5_func = pwdata[IFS_IN5_LSB +: IFS_W];
          s_d.in6_func = pwdata[IFS_IN6_LSB +: IFS_W];
        end
        default: s_d.rdata = s_q.rdata;
      endcase
    end
    // Read data caught in setup, held through access
    if (rd_setup) s_d.rdata = gpif_read(s_q, paddr, actual_motor_position);
    // Counter counts whether or not gearing is engaged; wraps freely
    if (dif.step_up && !dif.step_down)
    begin
      // One count up per decoded step
      s_d.ext_cnt = s_q.ext_cnt + 32'sh1;
    end
    else if (dif.step_down && !dif.step_up)
    begin
      // One count down per decoded step
      s_d.ext_cnt = s_q.ext_cnt - 32'sh1;
    end
    // Gearing: remainder kept exactly, command moves one count per clock.
    // At 50 MHz that is far above any pulse rate, so no practical limit.
    if (s_q.engaged && dd != 40'sh0)
    begin
      if (s_q.acc >= dd)
      begin
        s_d.cmd = s_q.cmd + 32'sh1;
        s_d.acc = s_q.acc - dd;
      end
      else if (s_q.acc <= -dd)
      begin
        s_d.cmd = s_q.cmd - 32'sh1;
        s_d.acc = s_q.acc + dd;
      end
      if (dif.step_up && !dif.step_down)
      begin
        // New input count adds its share after any carry this clock
        s_d.acc = s_d.acc + step;
      end
      else if (dif.step_down && !dif.step_up)
      begin
        // Down count takes its share back
        s_d.acc = s_d.acc - step;
      end
    end
    // Error for the position loop outside this block
    s_d.err = s_q.cmd - actual_motor_position;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.num <= NUM_RST;
      s_q.den <= DEN_RST;
      s_q.xres <= XRES_RST;
      s_q.mres <= MRES_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign prdata = s_q.rdata;
  assign position_command = s_q.cmd;
  assign position_error = s_q.err;
  // Correction direction removes the error
  assign move_fwd = s_q.err > 32'sh0;
  assign move_rev = s_q.err < 32'sh0;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic unity;
  assign unity = s_q.engaged && s_q.src == SRC_PDIR_CTRL && s_q.num == $signed(s_q.den) &&
    {2'b00, s_q.xres} == {s_q.mres, 2'b00} && s_q.den != 16'h0;

  cnt_up_a: assert property (dif.step_up && !dif.step_down |=> s_q.ext_cnt == $past(s_q.ext_cnt) + 32'sh1)
    else $error("Counter did not count up");
  cnt_down_a: assert property (dif.step_down && !dif.step_up |=> s_q.ext_cnt == $past(s_q.ext_cnt) - 32'sh1)
    else $error("Counter did not count down");
  cnt_hold_a: assert property (dif.step_up == dif.step_down |=> $stable(s_q.ext_cnt))
    else $error("Counter moved without a step");
  // Error register lags command and actual position by one clock
  err_form_a: assert property ($stable(s_q.cmd) && $stable(actual_motor_position) |=>
    s_q.err == $past(s_q.cmd) - $past(actual_motor_position))
    else $error("Position error not command minus actual");
  unity_gear_a: assert property ((unity && dif.step_up && !dif.step_down && s_q.acc == 40'sh0 && !psel)
    ##1 !psel |=> s_q.cmd == $past(s_q.cmd, 2) + 32'sh1)
    else $error("Unity ratio pulse did not give one count");
  gear_hold_a: assert property (!s_q.engaged |=> $stable(s_q.cmd))
    else $error("Command moved while gearing disengaged");
  rem_carry_a: assert property (s_q.engaged && dd != 40'sh0 && s_q.acc >= dd |=>
    s_q.cmd == $past(s_q.cmd) + 32'sh1)
    else $error("Remainder carry lost");
  src_mach_a: assert property (s_q.src == SRC_PDIR_MACH |-> dif.raw_a == mach_a_in && dif.kind == KIND_PDIR)
    else $error("Machine port not selected");
  src_fast_a: assert property (s_q.src == SRC_PDIR_CTRL && fast_sel |-> dif.raw_b == fast_in6)
    else $error("Fast input not selected");

  // Controller port pulse and direction when fast pins are not routed
  src_ctrl_a: assert property (s_q.src == SRC_PDIR_CTRL && !fast_sel |->
    dif.raw_a == ctrl_a_in && dif.raw_b == ctrl_b_in && dif.kind == KIND_PDIR)
    else $error("Controller port not selected");

  // Machine port quadrature follower
  src_quad_a: assert property (s_q.src == SRC_QUAD_MACH |->
    dif.raw_a == mach_a_in && dif.raw_b == mach_b_in && dif.kind == KIND_QUAD)
    else $error("Machine quadrature not selected");

  // Up/down counting only ever from the controller side
  src_updn_a: assert property (s_q.src == SRC_UPDN_CTRL |->
    dif.kind == KIND_UPDN && dif.raw_a == (fast_sel ? fast_in5 : ctrl_a_in))
    else $error("Up/down source not selected");

  // Spare selection codes decode nothing
  src_none_a: assert property (s_q.src > SRC_PDIR_MACH |-> dif.kind == KIND_NONE)
    else $error("Spare source code decoded");

  // Command moves at most one count per clock
  cmd_rate_a: assert property (s_q.cmd == $past(s_q.cmd) || s_q.cmd == $past(s_q.cmd) + 32'sh1 ||
    s_q.cmd == $past(s_q.cmd) - 32'sh1)
    else $error("Command jumped by more than one count");

  // Never both correction directions at once
  move_excl_a: assert property (!(move_fwd && move_rev))
    else $error("Both move directions asserted");

  // No correction request while the error is zero
  move_zero_a: assert property (s_q.err == 32'sh0 |-> !move_fwd && !move_rev)
    else $error("Move requested with zero error");

  // Counter wraps instead of saturating
  cnt_wrap_a: assert property (s_q.ext_cnt == 32'sh7fffffff && dif.step_up && !dif.step_down |=>
    s_q.ext_cnt == 32'sh80000000)
    else $error("Counter did not wrap");

  // A negative numerator drives the remainder the other way
  num_sign_a: assert property (s_q.engaged && s_q.num < 16'sh0 && s_q.acc == 40'sh0 && dd != 40'sh0 &&
    dif.step_up && !dif.step_down |=> s_q.acc <= 40'sh0)
    else $error("Numerator sign ignored");

  // Engage bit follows a control write
  wr_ctrl_a: assert property (wr_en && paddr == ADDR_CTRL |=> s_q.engaged == $past(pwdata[CTRL_ENGAGE_BIT]))
    else $error("Engage bit not written");

  // Zero wait states: ready in every access cycle
  apb_rdy_a: assert property (pready == (psel && penable))
    else $error("Ready not tied to access phase");
  apb_err_a: assert property (psel && penable && !gpif_mapped(paddr) |-> pslverr && pready)
    else $error("Unmapped access not answered with error");

  pdir_up_c: cover property (s_q.src == SRC_PDIR_CTRL && dif.step_up ##2 $changed(s_q.cmd));
  quad_dn_c: cover property (s_q.src == SRC_QUAD_MACH && dif.step_down);
  updn_c: cover property (s_q.src == SRC_UPDN_CTRL && dif.step_down ##[1:20] dif.step_up);
  neg_num_c: cover property (s_q.num < 16'sh0 && dif.step_up ##2 s_q.cmd < $past(s_q.cmd));
  // Single-ended fast pins seen counting
  fast_c: cover property (fast_sel && dif.step_down);
endmodule

// file: gpif_src_model.sv
`timescale 1ns/1ps
// Stand-in for the controller, PLC or handwheel on one pin pair
module gpif_src_model
(
  input wire logic pclk,
  output logic a,
  output logic b
);
  // Six cycles per phase keeps edges apart; closer pulses may merge in the synchronisers
  localparam int PH = 6;
  // Both lines rest low so a reset release never sees a spurious edge
  initial
  begin
    a = 1'b0;
    b = 1'b0;
  end
  // Direction level, settled long before the next pulse edge
  task automatic set_b(input logic v);
    b <= v;
    repeat (PH) @(posedge pclk);
  endtask
  // Rising pulses on line a: pulse input, or up count
  task automatic pulse_a(input int n);
    repeat (n)
    begin
      a <= 1'b1;
      repeat (PH) @(posedge pclk);
      a <= 1'b0;
      repeat (PH) @(posedge pclk);
    end
  endtask
  // Rising pulses on line b: down count
  task automatic pulse_b(input int n);
    repeat (n)
    begin
      b <= 1'b1;
      repeat (PH) @(posedge pclk);
      b <= 1'b0;
      repeat (PH) @(posedge pclk);
    end
  endtask
  // Whole quadrature cycles, a leading b when fwd is set
  task automatic quad(input int n, input logic fwd);
    repeat (n)
    begin
      {a, b} <= fwd ? 2'b10 : 2'b01;
      repeat (PH) @(posedge pclk);
      {a, b} <= 2'b11;
      repeat (PH) @(posedge pclk);
      {a, b} <= fwd ? 2'b01 : 2'b10;
      repeat (PH) @(posedge pclk);
      {a, b} <= 2'b00;
      repeat (PH) @(posedge pclk);
    end
  endtask
endmodule

// file: tb_gear_pulse_input_follower.sv
`timescale 1ns/1ps
module tb_gear_pulse_input_follower
  import gpif_pkg::*;
;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ca, cb, ma, mb, f5, f6; // Pin pairs from the three source models
  logic signed [31:0] actual_motor_position;
  logic signed [31:0] position_command;
  logic signed [31:0] position_error;
  logic move_fwd;
  logic move_rev;
  int err_total;
  int check_count;
  logic [31:0] rd;
  logic er;
  // Controller port, machine port and fast single-ended pins each get a source
  gpif_src_model src_c (.pclk(pclk), .a(ca), .b(cb));
  gpif_src_model src_m (.pclk(pclk), .a(ma), .b(mb));
  gpif_src_model src_f (.pclk(pclk), .a(f5), .b(f6));
  gpif_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ctrl_a_in(ca), .ctrl_b_in(cb), .mach_a_in(ma), .mach_b_in(mb), .fast_in5(f5), .fast_in6(f6),
    .actual_motor_position(actual_motor_position), .position_command(position_command),
    .position_error(position_error), .move_fwd(move_fwd), .move_rev(move_rev));
  // 50 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Comparison with counting; four-state so unknowns never match
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Verdict and end of run, shared with the watchdog
  task automatic complete_run;
    $display("Mismatches %0d, comparisons %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Reset held 16 cycles; clears counter and remainders
  task automatic apply_reset;
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  // One APB transfer; request held until pready is seen at an edge, plus an idle cycle
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Read one register and compare
  task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(rd, exp);
  endtask
  // Ratios first, control word last so gearing engages on a settled setup
  task automatic cfg(input logic [2:0] src, input logic [15:0] num, input logic [15:0] xres,
    input logic [15:0] mres, input logic eng);
    apb(1'b1, ADDR_NUM, {{16{num[15]}}, num});
    apb(1'b1, ADDR_DEN, 32'h1);
    apb(1'b1, ADDR_XRES, {16'h0, xres});
    apb(1'b1, ADDR_MRES, {16'h0, mres});
    apb(1'b1, ADDR_CTRL, {25'h0, src, 2'b00, 1'b1, eng});
  endtask
  // Wait for the command to settle, then check it and the input counter
  task automatic expect_pos(input logic [31:0] cnt, input logic [31:0] cmd);
    int n;
    n = 0;
    while (position_command !== cmd && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    repeat (4) @(posedge pclk);
    chk(position_command, cmd);
    rdchk(ADDR_EXTCNT, cnt);
  endtask
  // Reset values, unmapped access and read-only counter
  task automatic t_regs;
    rdchk(ADDR_NUM, 32'h1);
    rdchk(ADDR_DEN, 32'h1);
    rdchk(ADDR_XRES, 32'h4);
    rdchk(ADDR_MRES, 32'h1);
    rdchk(ADDR_CTRL, 32'h0);
    apb(1'b1, 8'h3c, 32'h5);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, ADDR_EXTCNT, 32'h5);
    chk({31'h0, er}, 32'h0);
    rdchk(ADDR_EXTCNT, 32'h0);
  endtask
  // Not engaged: counter moves, command stays
  task automatic t_idle;
    cfg(SRC_PDIR_CTRL, 16'h1, 16'h4, 16'h1, 1'b0);
    src_c.set_b(1'b1);
    src_c.pulse_a(2);
    src_c.set_b(1'b0);
    expect_pos(32'h2, 32'h0);
  endtask
  // Pulse and direction on controller port, unity gearing, then error and motion
  task automatic t_pdir;
    apply_reset();
    cfg(SRC_PDIR_CTRL, 16'h1, 16'h4, 16'h1, 1'b1);
    src_c.set_b(1'b1);
    src_c.pulse_a(5);
    src_c.set_b(1'b0);
    src_c.pulse_a(2);
    expect_pos(32'h3, 32'h3);
    actual_motor_position <= 32'sd1;
    repeat (4) @(posedge pclk);
    chk(position_error, 32'h2);
    chk({31'h0, move_fwd}, 32'h1);
    actual_motor_position <= 32'sd10;
    repeat (4) @(posedge pclk);
    chk(position_error, 32'hfffffff9);
    chk({31'h0, move_rev}, 32'h1);
    rdchk(ADDR_ERR, 32'hfffffff9);
    rdchk(ADDR_ACTUAL, 32'ha);
    rdchk(ADDR_CMD, 32'h3);
  endtask
  // Machine port, negative numerator, half a count per pulse
  task automatic t_mach;
    apply_reset();
    cfg(SRC_PDIR_MACH, 16'hfffe, 16'd1024, 16'd64, 1'b1);
    src_m.set_b(1'b1);
    src_m.pulse_a(6);
    src_m.set_b(1'b0);
    expect_pos(32'h6, 32'hfffffffd);
  endtask
  // Fast single-ended pins routed by function codes
  task automatic t_fast;
    apply_reset();
    apb(1'b1, ADDR_IFS, {19'h0, FUNC_DIR, 3'h0, FUNC_PULSE});
    cfg(SRC_PDIR_CTRL, 16'h1, 16'h4, 16'h1, 1'b1);
    src_f.set_b(1'b0);
    src_f.pulse_a(3);
    expect_pos(32'hfffffffd, 32'hfffffffd);
  endtask
  // Quadrature on both ports, resolution in lines
  task automatic t_quad;
    apply_reset();
    cfg(SRC_QUAD_CTRL, 16'h1, 16'd120, 16'd120, 1'b1);
    src_c.quad(2, 1'b1);
    src_c.quad(1, 1'b0);
    expect_pos(32'h4, 32'h4);
    apply_reset();
    cfg(SRC_QUAD_MACH, 16'h1, 16'd120, 16'd120, 1'b1);
    src_m.quad(1, 1'b0);
    expect_pos(32'hfffffffc, 32'hfffffffc);
  endtask
  // Up/down counting on the controller port
  task automatic t_updn;
    apply_reset();
    cfg(SRC_UPDN_CTRL, 16'h1, 16'h4, 16'h1, 1'b1);
    src_c.pulse_a(4);
    src_c.pulse_b(1);
    expect_pos(32'h3, 32'h3);
  endtask
  // Main sequence
  initial
  begin
    err_total = 0;
    check_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    actual_motor_position = 32'sd0;
    @(posedge pclk);
    apply_reset();
    t_regs();
    t_idle();
    t_pdir();
    t_mach();
    t_fast();
    t_quad();
    t_updn();
    complete_run();
  end
  // Watchdog well beyond the several hundred cycles the tests need
  initial
  begin
    #1ms;
    err_total++;
    complete_run();
  end
endmodule
